// ===== hdl/rat_pkg.sv
// Purpose: shared constants and carriers for the alarm and trim block
// Assumes: one 20 MHz clock, register port driven by the serial engine
// Notes: capacitance codes count 0.5 pF per pin, 0.25 pF for the load
package rat_pkg;
	// register byte addresses
	localparam logic [4:0] ADDR_STATUS    = 5'h07;
	localparam logic [4:0] ADDR_INT       = 5'h08;
	localparam logic [4:0] ADDR_ATR       = 5'h0A;
	localparam logic [4:0] ADDR_DTR       = 5'h0B;
	localparam logic [4:0] ADDR_ALM_FIRST = 5'h0C;
	localparam logic [4:0] ADDR_ALM_LAST  = 5'h11;
	localparam logic [4:0] ADDR_USR_FIRST = 5'h12;
	localparam logic [4:0] ADDR_USR_LAST  = 5'h19;
	// field positions
	localparam int SR_STATUS_AUTOCLEAR_BIT  = 7;
	localparam int SR_ALM_BIT   = 2;
	localparam int INT_IM_BIT   = 7;
	localparam int INT_ALARM_ARM_BIT = 6;
	localparam int INT_FOBAT_BIT = 4;
	localparam int INT_FO_LSB   = 0;
	localparam int ATR_BM_LSB   = 6;
	localparam int ALM_EN_BIT   = 7;
	localparam int DTR_SIGN_BIT = 2;
	// reset value of every stored byte
	localparam logic [7:0] RST_BYTE = 8'h00;
	// capacitance in 0.5 pF units
	localparam logic [6:0] CAP_FIXED = 7'h12;
	localparam logic [6:0] CAP_MSB   = 7'h20;
	// digital trim arithmetic
	localparam logic [5:0]  PPM_STEP   = 6'h14;
	localparam logic [19:0] PPM_FULL   = 20'hF_4240;
	localparam logic [15:0] OSC_COUNTS = 16'h8000;
	// alarm pulse timing
	localparam int PULSE_MS  = 250;
	localparam int CLK_KHZ   = 20000;
	localparam int PULSE_CYC = PULSE_MS * CLK_KHZ;
	localparam int PULSE_W   = 23;

	// register port request from the serial engine
	typedef struct packed {
		logic [4:0] addr;   // byte address
		logic [7:0] wdata;  // write byte
		logic       wr;     // one-cycle write strobe
		logic       rd;     // one-cycle completed read
	} rat_req_t;

	// running time, same byte layout as the alarm bytes
	typedef struct packed {
		logic [7:0] wday;
		logic [7:0] month;
		logic [7:0] date;
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
	} rat_time_t;

	// state of the trim prescaler
	typedef struct packed {
		logic        osc_meta;
		logic        osc_sync;
		logic        osc_prev;
		logic [15:0] cnt;
		logic [19:0] acc;
		logic        tick;
	} rat_trim_t;

	// state of the top block
	typedef struct packed {
		logic [7:0][7:0]     user;
		logic [5:0][7:0]     alarm;
		logic                status_autoclear;
		logic                alarm_flag;
		logic [7:0]          intc;
		logic [7:0]          load_cap_code;
		logic [2:0]          dtr;
		logic                bat_meta;
		logic                bat_sync;
		logic [PULSE_W-1:0]  pulse_cnt;
		logic                pulse_on;
		logic [7:0]          rdata;
		logic                irq_oe;
		logic [6:0]          cap;
	} rat_state_t;
endpackage

// ===== hdl/rat_cap.sv
// Purpose: load capacitance code for the crystal pins
// Assumes: inputs already registered
// Notes: purely combinational, the top registers the result
`timescale 1ns/10ps
module rat_cap (
	input  wire logic [5:0] code_in,     // load_cap_code
	input  wire logic [1:0] bat_off_in,  // battery_cap_offset
	input  wire logic       on_batt_in,  // running from backup supply
	output logic      [6:0] cap_out      // per pin, 0.5 pF units
);
	logic [6:0] base;  // value before battery offset

	// weights 16,8,4,2,1,0.5 pF with inverted top bit, plus fixed 9 pF
	always_comb
	begin
		base = rat_pkg::CAP_FIXED + {1'b0, ~code_in[5], code_in[4:0]}; // R1
		cap_out = base;
		if (on_batt_in) // R4
		begin
			unique case (bat_off_in)
				2'h1: cap_out = base - 7'h01;
				2'h2: cap_out = base + 7'h01;
				2'h3: cap_out = base + 7'h02;
				default: cap_out = base;
			endcase
		end
	end
endmodule

// ===== hdl/rat_trim.sv
// Purpose: trimmed one-second prescaler from the crystal clock
// Assumes: osc_clk_in is the 32768 Hz oscillator, asynchronous here
// Notes: a fractional accumulator spreads the ppm evenly
`timescale 1ns/10ps
module rat_trim (
	input  wire logic       ref_clk_in,  // system clock
	input  wire logic       rst_in,      // synchronous reset
	input  wire logic       osc_clk_in,  // crystal clock level
	input  wire logic [2:0] dtr_in,      // digital trim code
	output logic            sec_tick_out // one-cycle second pulse
);
	rat_pkg::rat_trim_t s;     // registered state
	rat_pkg::rat_trim_t n;     // next state
	logic [5:0]         ppm;   // selected magnitude
	logic [19:0]        sum;   // accumulator plus magnitude
	logic [1:0]         step;  // counts credited this edge
	logic [15:0]        csum;  // counter plus step

	// each rising crystal edge adds ppm; a full million adds or drops one count
	always_comb
	begin
		n = s;
		n.osc_meta = osc_clk_in;
		n.osc_sync = s.osc_meta;
		n.osc_prev = s.osc_sync;
		n.tick = 1'b0;
		ppm = 6'(dtr_in[1:0]) * rat_pkg::PPM_STEP; // R6
		sum = s.acc + 20'(ppm);
		step = 2'h1;
		csum = s.cnt;
		if (s.osc_sync && !s.osc_prev)
		begin
			n.acc = sum;
			if (sum >= rat_pkg::PPM_FULL) // R8
			begin
				n.acc = sum - rat_pkg::PPM_FULL;
				// positive trim shortens the second, negative lengthens it
				step = dtr_in[rat_pkg::DTR_SIGN_BIT] ? 2'h0 : 2'h2; // R5
			end
			csum = s.cnt + 16'(step);
			n.cnt = csum;
			if (csum >= rat_pkg::OSC_COUNTS) // R7
			begin
				n.cnt = csum - rat_pkg::OSC_COUNTS;
				n.tick = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
			s <= '0;
		else
			s <= n;
	end

	assign sec_tick_out = s.tick;
endmodule

// ===== hdl/rat_top.sv
// Purpose: alarm, trim settings and user bytes of a real-time clock
// Assumes: serial engine delivers one-cycle register strobes
// Notes: time counters live outside and report each advance
// How it works
// R1: pin capacitance from weighted code plus 9 pF
// R2: load is half, 4.5 to 20.25 pF
// R3: both crystal pins get identical capacitance
// R4: backup supply adds two-bit capacitance offset
// R5: digital trim top bit is the sign
// R6: low trim bits weigh 40 and 20 ppm
// R7: trim changes average counts per second
// R8: trim adds or skips prescaler counts
// R9: alarm bytes match time bytes, bit7 enables
// R10: all enabled fields must equal the time
// R11: compare when the time advances
// R12: single mode holds pin low until cleared
// R13: repeat mode pulses pin low per match
// R14: repeat mode sets flag every match
// R15: write zero clears flag; autoclear on read
// R16: alarm bytes at 0Ch through 11h
// R17: order seconds, minutes, hours, date, month, weekday
// R18: eight user bytes at 12h through 19h
// R19: repeat pulse is active low, 250 ms
// R20: frequency output overrides and disables alarm
`timescale 1ns/10ps
module rat_top #(
	parameter int PULSE_CYCLES = rat_pkg::PULSE_CYC  // repeat pulse length
) (
	input  wire logic              ref_clk_in,          // 20 MHz clock
	input  wire logic              rst_in,              // synchronous reset
	input  wire rat_pkg::rat_req_t reg_req_in,          // register request
	output logic [7:0]             reg_rdata_out,       // read byte
	input  wire rat_pkg::rat_time_t time_now_in,        // running time
	input  wire logic              time_tick_in,        // time just advanced
	input  wire logic              battery_mode_in,     // backup supply active
	input  wire logic              osc_clk_in,          // crystal clock
	input  wire logic              fout_level_in,       // frequency wave
	output logic                   second_tick_out,     // trimmed second
	output logic                   alarm_flag_out,      // alarm status
	output logic                   irq_pin_out,         // shared pin level
	output logic                   irq_oe_out,          // pin pulled low
	output logic [6:0]             first_pin_cap_out,   // 0.5 pF units
	output logic [6:0]             second_pin_cap_out,  // 0.5 pF units
	output logic [6:0]             load_cap_out         // 0.25 pF units
);
	// pulse counter must hold the chosen length
	if (PULSE_CYCLES < 1 || PULSE_CYCLES >= 2 ** rat_pkg::PULSE_W)
	begin : bad_pulse
		$error("PULSE_CYCLES out of range");
	end

	localparam logic [rat_pkg::PULSE_W-1:0] PULSE_LAST =
		rat_pkg::PULSE_W'(PULSE_CYCLES - 1);

	rat_pkg::rat_state_t s;           // registered state
	rat_pkg::rat_state_t n;           // next state
	logic               match;        // enabled fields equal the time
	logic [6:0]         cap_calc;     // capacitance before register
	logic [3:0]         fo_sel;       // freq_out_select
	logic               alarm_live;   // alarm armed and pin free
	logic               hit;          // alarm trigger this cycle
	logic               clr;          // flag clear this cycle
	logic               pin_off;      // pin disabled on battery
	logic               repeat_mode;  // alarm_repeat_select

	// field compare against the running time
	rat_alarm_cmp u_cmp (
		.alarm_in (s.alarm),
		.time_in  (time_now_in),
		.match_out(match)
	);

	// capacitance code for the crystal pins
	rat_cap u_cap (
		.code_in   (s.load_cap_code[5:0]),
		.bat_off_in(s.load_cap_code[7:rat_pkg::ATR_BM_LSB]),
		.on_batt_in(s.bat_sync),
		.cap_out   (cap_calc)
	);

	// trimmed second prescaler
	rat_trim u_trim (
		.ref_clk_in  (ref_clk_in),
		.rst_in      (rst_in),
		.osc_clk_in  (osc_clk_in),
		.dtr_in      (s.dtr),
		.sec_tick_out(second_tick_out)
	);

	// read multiplexer, unmapped bytes read zero
	function automatic logic [7:0] read_byte(
		input rat_pkg::rat_state_t st,
		input logic [4:0]          a
	);
		logic [7:0] v;
		v = rat_pkg::RST_BYTE;
		if (a == rat_pkg::ADDR_STATUS)
		begin
			v[rat_pkg::SR_STATUS_AUTOCLEAR_BIT] = st.status_autoclear;
			v[rat_pkg::SR_ALM_BIT] = st.alarm_flag;
		end
		else if (a == rat_pkg::ADDR_INT)
			v = st.intc;
		else if (a == rat_pkg::ADDR_ATR)
			v = st.load_cap_code;
		else if (a == rat_pkg::ADDR_DTR)
			v = {5'h00, st.dtr};
		else if (a >= rat_pkg::ADDR_ALM_FIRST && a <= rat_pkg::ADDR_ALM_LAST)
			v = st.alarm[3'(a - rat_pkg::ADDR_ALM_FIRST)]; // R16
		else if (a >= rat_pkg::ADDR_USR_FIRST && a <= rat_pkg::ADDR_USR_LAST)
			v = st.user[3'(a - rat_pkg::ADDR_USR_FIRST)]; // R18
		return v;
	endfunction

	// mode decode from the control byte
	always_comb
	begin
		fo_sel = s.intc[rat_pkg::INT_FO_LSB +: 4];
		repeat_mode = s.intc[rat_pkg::INT_IM_BIT];
		alarm_live = s.intc[rat_pkg::INT_ALARM_ARM_BIT] && (fo_sel == 4'h0); // R20
		hit = time_tick_in && match && alarm_live; // R11
		pin_off = s.bat_sync && s.intc[rat_pkg::INT_FOBAT_BIT];
	end

	// flag clear by writing zero or by reading with autoclear
	always_comb
	begin
		clr = 1'b0;
		if (reg_req_in.addr == rat_pkg::ADDR_STATUS)
		begin
			if (reg_req_in.wr && !reg_req_in.wdata[rat_pkg::SR_ALM_BIT])
				clr = 1'b1; // R15
			if (reg_req_in.rd && s.status_autoclear)
				clr = 1'b1; // R15
		end
	end

	// next state: register writes, alarm flag, pulse timer, pin
	always_comb
	begin
		n = s;
		n.bat_meta = battery_mode_in;
		n.bat_sync = s.bat_meta;
		// register writes
		if (reg_req_in.wr)
		begin
			if (reg_req_in.addr == rat_pkg::ADDR_STATUS)
				n.status_autoclear = reg_req_in.wdata[rat_pkg::SR_STATUS_AUTOCLEAR_BIT];
			else if (reg_req_in.addr == rat_pkg::ADDR_INT)
				n.intc = reg_req_in.wdata;
			else if (reg_req_in.addr == rat_pkg::ADDR_ATR)
				n.load_cap_code = reg_req_in.wdata;
			else if (reg_req_in.addr == rat_pkg::ADDR_DTR)
				n.dtr = reg_req_in.wdata[2:0];
			else if (reg_req_in.addr >= rat_pkg::ADDR_ALM_FIRST &&
				reg_req_in.addr <= rat_pkg::ADDR_ALM_LAST)
				n.alarm[3'(reg_req_in.addr - rat_pkg::ADDR_ALM_FIRST)] =
					reg_req_in.wdata; // R17
			else if (reg_req_in.addr >= rat_pkg::ADDR_USR_FIRST &&
				reg_req_in.addr <= rat_pkg::ADDR_USR_LAST)
				n.user[3'(reg_req_in.addr - rat_pkg::ADDR_USR_FIRST)] =
					reg_req_in.wdata; // R18
		end
		// read data captured on the read strobe
		if (reg_req_in.rd)
			n.rdata = read_byte(s, reg_req_in.addr);
		// a trigger wins over a clear in the same cycle
		n.alarm_flag = hit || (s.alarm_flag && !clr); // R14
		// repeat pulse timer, stopped when the alarm is disarmed
		if (!alarm_live || !repeat_mode)
		begin
			n.pulse_on = 1'b0;
			n.pulse_cnt = '0;
		end
		else if (hit)
		begin
			n.pulse_on = 1'b1; // R13
			n.pulse_cnt = PULSE_LAST; // R19
		end
		else if (s.pulse_cnt != '0)
			n.pulse_cnt = s.pulse_cnt - 1'b1;
		else
			n.pulse_on = 1'b0;
		// shared pin pulled low
		if (pin_off)
			n.irq_oe = 1'b0;
		else if (fo_sel != 4'h0)
			n.irq_oe = !fout_level_in; // R20
		else if (alarm_live && repeat_mode)
			n.irq_oe = n.pulse_on; // R19
		else if (alarm_live)
			n.irq_oe = n.alarm_flag; // R12
		else
			n.irq_oe = 1'b0;
		n.cap = cap_calc; // R3
	end

	// state register
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
			s <= '0;
		else
			s <= n;
	end

	// outputs from the state register, except the pin level tied low
	assign reg_rdata_out = s.rdata;
	assign alarm_flag_out = s.alarm_flag;
	assign irq_pin_out = 1'b0;
	assign irq_oe_out = s.irq_oe;
	assign first_pin_cap_out = s.cap; // R3
	assign second_pin_cap_out = s.cap; // R3
	assign load_cap_out = s.cap; // R2
endmodule

// Purpose: compare alarm bytes with the running time
// Assumes: time bytes share the alarm encoding
// Notes: no field enabled means no match
module rat_alarm_cmp (
	input  wire logic [5:0][7:0]    alarm_in,  // seconds first
	input  wire rat_pkg::rat_time_t time_in,   // running time
	output logic                    match_out  // all enabled fields equal
);
	logic [5:0][7:0] t;   // time as byte array
	logic [5:0]      ok;  // per field pass
	logic [5:0]      en;  // per field enable

	assign t = time_in;

	// per field: disabled passes, enabled compares seven bits
	for (genvar i = 0; i < 6; i++)
	begin : g_fld
		assign en[i] = alarm_in[i][rat_pkg::ALM_EN_BIT]; // R9
		assign ok[i] = !en[i] || (alarm_in[i][6:0] == t[i][6:0]); // R9
	end

	assign match_out = (&ok) && (|en); // R10
endmodule

// ===== bench/rat_top_properties.sv
// Purpose: port checker for the alarm and trim block
// Assumes: INT and SR are shadowed from register writes seen at the port
// Notes: repeat pulse length is counted in helper logic
`timescale 1ns/10ps
module rat_top_properties #(
	parameter int PULSE_CYCLES = 8  // repeat pulse length
) (
	input wire logic               ref_clk_in,
	input wire logic               rst_in,
	input wire rat_pkg::rat_req_t  reg_req_in,
	input wire logic [7:0]         reg_rdata_out,
	input wire rat_pkg::rat_time_t time_now_in,
	input wire logic               time_tick_in,
	input wire logic               battery_mode_in,
	input wire logic               osc_clk_in,
	input wire logic               fout_level_in,
	input wire logic               second_tick_out,
	input wire logic               alarm_flag_out,
	input wire logic               irq_pin_out,
	input wire logic               irq_oe_out,
	input wire logic [6:0]         first_pin_cap_out,
	input wire logic [6:0]         second_pin_cap_out,
	input wire logic [6:0]         load_cap_out
);
	logic [7:0] intc_reg;  // shadow of interrupt control
	logic       status_autoclear_reg;  // shadow of autoclear
	logic [7:0] hi_reg;    // run length of pin pulled low
	wire sr_hit = reg_req_in.addr == rat_pkg::ADDR_STATUS;  // status byte addressed
	wire fo     = intc_reg[3:0] != 4'h0 && !intc_reg[4];     // frequency owns the pin
	wire live   = intc_reg[6] && intc_reg[3:0] == 4'h0 && !intc_reg[4];
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	// shadows follow host writes
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			intc_reg <= 8'h00;
			status_autoclear_reg <= 1'b0;
			hi_reg   <= 8'h00;
		end
		else
		begin
			if (reg_req_in.wr && reg_req_in.addr == rat_pkg::ADDR_INT)
				intc_reg <= reg_req_in.wdata;
			if (reg_req_in.wr && sr_hit)
				status_autoclear_reg <= reg_req_in.wdata[7];
			hi_reg <= irq_oe_out ? hi_reg + 8'h01 : 8'h00;
		end
	end
	a_pins_equal: assert property (first_pin_cap_out == second_pin_cap_out)
		else $error("pin capacitances differ");
	a_load_follows: assert property (load_cap_out == first_pin_cap_out)
		else $error("load capacitance not half of pin value");
	a_rdata_holds: assert property (!reg_req_in.rd |=> $stable(reg_rdata_out))
		else $error("read byte changed without a read");
	a_flag_cleared: assert property (reg_req_in.wr && sr_hit && !reg_req_in.wdata[2]
		&& !time_tick_in |=> !alarm_flag_out) else $error("flag survived a clear");
	a_autoclear_read: assert property (reg_req_in.rd && sr_hit && status_autoclear_reg
		&& !time_tick_in |=> !alarm_flag_out) else $error("flag survived autoclear");
	a_flag_needs_tick: assert property ($rose(alarm_flag_out) |-> $past(time_tick_in))
		else $error("flag rose without a time advance");
	a_single_holds: assert property (live && !intc_reg[7] && alarm_flag_out
		&& $stable(intc_reg) |-> irq_oe_out) else $error("pin released while flag set");
	a_pulse_length: assert property (live && intc_reg[7] && $fell(irq_oe_out)
		&& $stable(intc_reg) |-> hi_reg == PULSE_CYCLES) else $error("bad pulse length");
	a_fout_drives: assert property (fo |=> irq_oe_out == !$past(fout_level_in))
		else $error("pin not following frequency wave");
	a_fout_no_alarm: assert property (fo && !alarm_flag_out |=> !alarm_flag_out)
		else $error("alarm fired while frequency output on");
endmodule
bind rat_top rat_top_properties #(.PULSE_CYCLES(PULSE_CYCLES)) u_props (
	.ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_req_in(reg_req_in),
	.reg_rdata_out(reg_rdata_out), .time_now_in(time_now_in), .time_tick_in(time_tick_in),
	.battery_mode_in(battery_mode_in), .osc_clk_in(osc_clk_in),
	.fout_level_in(fout_level_in), .second_tick_out(second_tick_out),
	.alarm_flag_out(alarm_flag_out), .irq_pin_out(irq_pin_out), .irq_oe_out(irq_oe_out),
	.first_pin_cap_out(first_pin_cap_out), .second_pin_cap_out(second_pin_cap_out),
	.load_cap_out(load_cap_out));

// ===== bench/rat_host.sv
// Purpose: host side of the register port
// Assumes: one-cycle strobes, read byte valid one edge after the read
// Notes: released address and data show the inverse of the last value
`timescale 1ns/10ps
module rat_host (
	input  wire logic        clk_in,    // system clock
	input  wire logic [7:0]  rdata_in,  // read byte
	output rat_pkg::rat_req_t req_out   // register request
);
	initial req_out = '0;
	// single byte write, also used to clear the flag with a zero
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
	begin
		@(negedge clk_in);
		req_out = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(negedge clk_in);
		req_out = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
	end
	endtask
	// single byte read, sampled once the registered byte has settled
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
	begin
		@(negedge clk_in);
		req_out = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(negedge clk_in);
		req_out = '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
		@(negedge clk_in);
		d = rdata_in;
	end
	endtask
endmodule

// ===== bench/rat_alarm_and_trim_tb.sv
// Purpose: self-checking bench for the alarm and trim block
// Assumes: short repeat pulse of 8 cycles, crystal clock held still
// Notes: register rows first, then alarm, frequency and reset cases
`timescale 1ns/10ps
module rat_alarm_and_trim_tb;
	typedef struct packed {
		logic [4:0] a;  // address
		logic [7:0] d;  // written byte
		logic       b;  // backup supply
		logic [7:0] r;  // expected read
		logic [6:0] c;  // expected pin capacitance
	} rat_row_t;
	localparam rat_row_t ROWS [20] = '{
		'{5'h0C, 8'hB0, 1'b0, 8'hB0, 7'h32}, '{5'h0D, 8'h81, 1'b0, 8'h81, 7'h32},
		'{5'h0E, 8'h91, 1'b0, 8'h91, 7'h32}, '{5'h0F, 8'h7F, 1'b0, 8'h7F, 7'h32},
		'{5'h10, 8'h81, 1'b0, 8'h81, 7'h32}, '{5'h11, 8'h86, 1'b0, 8'h86, 7'h32},
		'{5'h12, 8'hA5, 1'b0, 8'hA5, 7'h32}, '{5'h19, 8'h5A, 1'b0, 8'h5A, 7'h32},
		'{5'h1A, 8'hFF, 1'b0, 8'h00, 7'h32}, '{5'h09, 8'hFF, 1'b0, 8'h00, 7'h32},
		'{5'h0B, 8'hFF, 1'b0, 8'h07, 7'h32}, '{5'h07, 8'h84, 1'b0, 8'h80, 7'h32},
		'{5'h07, 8'h00, 1'b0, 8'h00, 7'h32}, '{5'h0A, 8'h20, 1'b0, 8'h20, 7'h12},
		'{5'h0A, 8'h1F, 1'b0, 8'h1F, 7'h51}, '{5'h0A, 8'h40, 1'b1, 8'h40, 7'h31},
		'{5'h0A, 8'h80, 1'b1, 8'h80, 7'h33}, '{5'h0A, 8'hC0, 1'b1, 8'hC0, 7'h34},
		'{5'h0A, 8'hC0, 1'b0, 8'hC0, 7'h32}, '{5'h0A, 8'h00, 1'b0, 8'h00, 7'h32}};
	logic ref_clk, rst, tick, batt, fout, flag, oe;
	logic [6:0] cap, load;
	logic [7:0] rdata, rd;
	rat_pkg::rat_req_t  req;
	rat_pkg::rat_time_t now;
	int failures = 0;
	int samples_checked = 0;
	rat_top #(.PULSE_CYCLES(8)) uut (.ref_clk_in(ref_clk), .rst_in(rst), .reg_req_in(req),
		.reg_rdata_out(rdata), .time_now_in(now), .time_tick_in(tick),
		.battery_mode_in(batt), .osc_clk_in(1'b0), .fout_level_in(fout),
		.second_tick_out(), .alarm_flag_out(flag), .irq_pin_out(), .irq_oe_out(oe),
		.first_pin_cap_out(cap), .second_pin_cap_out(), .load_cap_out(load));
	rat_host host (.clk_in(ref_clk), .rdata_in(rdata), .req_out(req));
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic check(input string n, input logic [7:0] got, input logic [7:0] exp);
	begin
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, exp, got);
		end
	end
	endtask
	// one time advance to minutes mn, seconds sc
	task automatic hit(input logic [7:0] mn, input logic [7:0] sc);
	begin
		@(negedge ref_clk);
		now = {32'h0000_0000, mn, sc};
		tick = 1'b1;
		@(negedge ref_clk);
		tick = 1'b0;
	end
	endtask
	task automatic tally_and_finish;
	begin
		if (failures == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask
	initial
	begin
		repeat (3000) @(posedge ref_clk);
		failures++;
		tally_and_finish();
	end
	initial
	begin
		{rst, tick, batt, fout} = 4'h8;
		now = '0;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		check("flag after reset", flag, 8'h00);
		check("oe after reset", oe, 8'h00);
		foreach (ROWS[i])
		begin
			batt = ROWS[i].b;
			host.wr(ROWS[i].a, ROWS[i].d);
			host.rd(ROWS[i].a, rd);
			repeat (3) @(negedge ref_clk);
			check("read back", rd, ROWS[i].r);
			check("pin cap", cap, ROWS[i].c);
			check("load cap", load, ROWS[i].c);
		end
		// seconds at 00 and minutes at 30 take part, the other fields sit out
		host.wr(5'h0C, 8'h80);
		host.wr(5'h0D, 8'hB0);
		for (int k = 14; k < 18; k++)
			host.wr(5'(k), 8'h00);
		host.wr(5'h08, 8'h40);
		hit(8'h31, 8'h00);
		check("minute miss", flag, 8'h00);
		now = {32'h0000_0000, 8'h30, 8'h00};
		repeat (2) @(negedge ref_clk);
		check("no advance", flag, 8'h00);
		hit(8'h30, 8'h00);
		repeat (20) @(negedge ref_clk);
		check("single flag", flag, 8'h01);
		check("single oe", oe, 8'h01);
		host.wr(rat_pkg::ADDR_STATUS, 8'h00);
		check("flag cleared", flag, 8'h00);
		check("oe released", oe, 8'h00);
		host.wr(rat_pkg::ADDR_STATUS, 8'h80);
		hit(8'h30, 8'h00);
		host.rd(rat_pkg::ADDR_STATUS, rd);
		check("status read", rd, 8'h84);
		check("autoclear", flag, 8'h00);
		host.wr(rat_pkg::ADDR_STATUS, 8'h00);
		host.wr(5'h0C, 8'h00);
		host.wr(5'h0D, 8'h00);
		hit(8'h30, 8'h00);
		check("none enabled", flag, 8'h00);
		host.wr(5'h0C, 8'h80);
		host.wr(5'h08, 8'hC0);
		repeat (2)
		begin
			hit(8'h00, 8'h00);
			check("repeat flag", flag, 8'h01);
			check("pulse on", oe, 8'h01);
			repeat (12) @(negedge ref_clk);
			check("pulse off", oe, 8'h00);
			// clear so that the next match must set the flag again
			host.wr(rat_pkg::ADDR_STATUS, 8'h00);
			check("repeat cleared", flag, 8'h00);
		end
		host.wr(rat_pkg::ADDR_STATUS, 8'h00);
		host.wr(5'h08, 8'h41);
		for (int v = 0; v < 2; v++)
		begin
			fout = v[0];
			repeat (2) @(negedge ref_clk);
			check("fout pin", oe, {7'h00, ~v[0]});
		end
		hit(8'h00, 8'h00);
		check("fout blocks", flag, 8'h00);
		host.wr(5'h08, 8'h40);
		hit(8'h00, 8'h00);
		rst = 1'b1;
		repeat (3) @(negedge ref_clk);
		check("flag in reset", flag, 8'h00);
		check("rdata in reset", rdata, 8'h00);
		rst = 1'b0;
		tally_and_finish();
	end
endmodule
